//--- rtl/dilp_ctrl.sv
// Interrupt prioritiser, nesting, idle and power-down sequencer
//
// Notes on behaviour
// - Eleven sources plus reset; ten maskable sources share the mask.
// - Four dedicated pins; serial port 1 alternate adds two pins, flag in/out.
// - Fixed priority: power-down, pin A, level 1, level 0, serial 0, edge, DMA, serial 1, timer.
// - Reset vector 0000, power-down 002C, others 0004 to 0028 by four.
// - Pin A and alternate pins selectable edge or level in control register.
// - Level pins always level sensitive; edge pin always edge sensitive.
// - Mask gates each request; highest unmasked wins; power-down ignores mask.
// - Control bit chooses nested preemption or sequential servicing.
// - All interrupts blocked one cycle after a mask register write.
// - Write-only force/clear register sets or clears pending requests.
// - Status pushed and popped on a twelve-level on-chip stack.
// - Global enable gates all servicing including power-down; enabled after reset.
// - Resume within 400 input clocks after leaving power-down.
// - With oscillator off, wait about 4096 input clocks before resuming.
// - Power-down started by request pin or software force bit.
// - Power-down interrupt precedes dormancy; usable as nonmaskable edge interrupt.
// - Context bit picks saved state or cleared context on wake.
// - Reset ends power-down.
// - Acknowledge output asserted once power-down actually entered.
// - Idle waits for an unmasked interrupt, then continues after idle.
// - DMA and autobuffer cycle steals continue while idle.
// - Slow idle divides the internal clock by the idle operand; here the operand is a code and the divisor is 8 shifted left by it.
// - Divisor 16, 32, 64 or 128; peripheral clocks follow; none means standard.
// - Slow idle exits within divisor cycles of an enabled interrupt.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dilp_ctrl
    import dilp_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    input wire logic prog_sense_int_pin_a_n,
    input wire logic level_int_pin_0_n,
    input wire logic level_int_pin_1_n,
    input wire logic edge_int_pin_n,
    input wire logic alt_int_pin_0_n,
    input wire logic alt_int_pin_1_n,
    input wire logic alt_flag_in,
    input wire logic power_down_request_pin_n,
    input wire logic sp0_tx_req,
    input wire logic sp0_rx_req,
    input wire logic sp1_tx_req,
    input wire logic sp1_rx_req,
    input wire logic byte_dma_port_req,
    input wire logic timer_req,
    input wire logic flag_out_value,
    input wire logic int_return,
    input wire logic [15:0] status_in,
    output logic [15:0] status_out,
    output logic int_take,
    output logic [13:0] int_vector,
    output logic alt_flag_out,
    output logic alt_flag_in_seen,
    output logic power_down_ack_pin,
    output logic ctx_clear,
    output logic core_run,
    output logic clk_en,
    output logic stack_overflow
);
    typedef struct packed {
        logic [10:0] mask;
        logic [7:0] ctrl;
        logic mask_block;
        logic [11:0] active;
        logic [STACK_DEPTH-1:0][15:0] stack;
        logic [3:0] sp;
        dilp_pstate_t ps;
        logic [2:0] div_code;
        logic [7:0] div_cnt;
        logic [13:0] wait_cnt;
        logic pwd_pin_prev_n;
        logic pwd_pend;
        logic pwd_force;
        logic pwd_active;
        logic [31:0] rdata;
        logic [15:0] status_out;
        logic int_take;
        logic [13:0] int_vector;
        logic alt_flag_out;
        logic alt_flag_in_seen;
        logic ack;
        logic ctx_clear;
        logic core_run;
        logic clk_en;
        logic ovf;
    } dilp_st_t;
    dilp_st_t st_reg;
    dilp_st_t st_next;

    logic [10:0] raw_req;
    logic [10:0] pend_req;
    logic [10:0] fc_force;
    logic [10:0] fc_clear;
    logic [10:0] serviced;
    logic [2:0] sense_edge_a;
    logic sp1_alt;
    logic [3:0] win_idx;
    logic win_valid;
    logic [7:0] div_len;
    logic [13:0] wake_len;
    logic fc_wr;

    assign sp1_alt = st_reg.ctrl[CTRL_SP1_ALT];
    assign fc_wr = wr_en && (addr == ADDR_FC);
    assign fc_force = fc_wr ? wdata[MASKABLE-1:0] : 11'h000;
    assign fc_clear = fc_wr ? wdata[FC_CLR_LSB +: MASKABLE] : 11'h000;
    assign sense_edge_a = {st_reg.ctrl[CTRL_SENSE_ALT1], st_reg.ctrl[CTRL_SENSE_ALT0],
        st_reg.ctrl[CTRL_SENSE_A]};

    // Pin-sourced requests; pin A sense programmable, fixed sense on the others
    dilp_sense u_psa (.clk(clk), .arst_n(arst_n), .req_n(prog_sense_int_pin_a_n),
        .edge_mode(sense_edge_a[0]), .force_set(fc_force[SRC_PSA-1]),
        .clear(fc_clear[SRC_PSA-1] || serviced[SRC_PSA-1]), .request(pend_req[SRC_PSA-1]));
    dilp_sense u_lvl1 (.clk(clk), .arst_n(arst_n), .req_n(level_int_pin_1_n),
        .edge_mode(1'b0), .force_set(fc_force[SRC_LVL1-1]),
        .clear(fc_clear[SRC_LVL1-1] || serviced[SRC_LVL1-1]), .request(pend_req[SRC_LVL1-1]));
    dilp_sense u_lvl0 (.clk(clk), .arst_n(arst_n), .req_n(level_int_pin_0_n),
        .edge_mode(1'b0), .force_set(fc_force[SRC_LVL0-1]),
        .clear(fc_clear[SRC_LVL0-1] || serviced[SRC_LVL0-1]), .request(pend_req[SRC_LVL0-1]));
    dilp_sense u_edge (.clk(clk), .arst_n(arst_n), .req_n(edge_int_pin_n),
        .edge_mode(1'b1), .force_set(fc_force[SRC_EDGE-1]),
        .clear(fc_clear[SRC_EDGE-1] || serviced[SRC_EDGE-1]), .request(pend_req[SRC_EDGE-1]));
    // Serial port 1 lines double as alternate pins
    dilp_sense u_sp1tx (.clk(clk), .arst_n(arst_n),
        .req_n(sp1_alt ? alt_int_pin_1_n : !sp1_tx_req),
        .edge_mode(sp1_alt ? sense_edge_a[2] : 1'b1), .force_set(fc_force[SRC_SP1_TX-1]),
        .clear(fc_clear[SRC_SP1_TX-1] || serviced[SRC_SP1_TX-1]),
        .request(pend_req[SRC_SP1_TX-1]));
    dilp_sense u_sp1rx (.clk(clk), .arst_n(arst_n),
        .req_n(sp1_alt ? alt_int_pin_0_n : !sp1_rx_req),
        .edge_mode(sp1_alt ? sense_edge_a[1] : 1'b1), .force_set(fc_force[SRC_SP1_RX-1]),
        .clear(fc_clear[SRC_SP1_RX-1] || serviced[SRC_SP1_RX-1]),
        .request(pend_req[SRC_SP1_RX-1]));
    // Internal peripheral pulses latched as edges
    dilp_sense u_sp0tx (.clk(clk), .arst_n(arst_n), .req_n(!sp0_tx_req), .edge_mode(1'b1),
        .force_set(fc_force[SRC_SP0_TX-1]),
        .clear(fc_clear[SRC_SP0_TX-1] || serviced[SRC_SP0_TX-1]),
        .request(pend_req[SRC_SP0_TX-1]));
    dilp_sense u_sp0rx (.clk(clk), .arst_n(arst_n), .req_n(!sp0_rx_req), .edge_mode(1'b1),
        .force_set(fc_force[SRC_SP0_RX-1]),
        .clear(fc_clear[SRC_SP0_RX-1] || serviced[SRC_SP0_RX-1]),
        .request(pend_req[SRC_SP0_RX-1]));
    dilp_sense u_byte_dma_port (.clk(clk), .arst_n(arst_n), .req_n(!byte_dma_port_req), .edge_mode(1'b1),
        .force_set(fc_force[SRC_BYTE_DMA_PORT-1]),
        .clear(fc_clear[SRC_BYTE_DMA_PORT-1] || serviced[SRC_BYTE_DMA_PORT-1]), .request(pend_req[SRC_BYTE_DMA_PORT-1]));
    dilp_sense u_tmr (.clk(clk), .arst_n(arst_n), .req_n(!timer_req), .edge_mode(1'b1),
        .force_set(fc_force[SRC_TIMER-1]),
        .clear(fc_clear[SRC_TIMER-1] || serviced[SRC_TIMER-1]),
        .request(pend_req[SRC_TIMER-1]));
    assign pend_req[MASKABLE-1] = 1'b0;
    assign raw_req = pend_req;

    // Priority pick over power-down plus masked sources
    always_comb begin
        logic [11:0] cand;
        logic [11:0] higher;
        cand = {1'b0, raw_req[9:0] & st_reg.mask[9:0], st_reg.pwd_pend};
        higher = 12'hfff;
        win_idx = 4'h0;
        win_valid = 1'b0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (cand[i]) begin
                win_idx = 4'(i);
                win_valid = 1'b1;
            end
        end
        // Nested mode: only higher than any running handler; sequential: none running
        for (int i = 0; i < NUM_SRC; i++) begin
            if (st_reg.active[i]) begin
                higher = higher & ((12'h001 << i) - 12'h001);
            end
        end
        if (st_reg.active != 12'h000) begin
            if (!st_reg.ctrl[CTRL_NEST] || !higher[win_idx]) begin
                win_valid = 1'b0;
            end
        end
    end

    assign div_len = DIV_BASE << st_reg.div_code;
    assign wake_len = st_reg.ctrl[CTRL_OSC_OFF] ? 14'(OSC_WAIT_CYC) : 14'(RECOVER_CYC);

    always_comb begin
        logic take;
        logic idle_cmd;
        st_next = st_reg;
        serviced = 11'h000;
        st_next.int_take = 1'b0;
        st_next.ctx_clear = 1'b0;
        st_next.rdata = 32'h0000_0000;
        st_next.mask_block = 1'b0;
        st_next.pwd_pin_prev_n = power_down_request_pin_n;
        idle_cmd = 1'b0;
        take = 1'b0;
        // Power-down request: pin falling edge or software force
        if ((st_reg.pwd_pin_prev_n && !power_down_request_pin_n) || st_reg.pwd_force) begin
            st_next.pwd_pend = 1'b1;
        end
        st_next.pwd_force = 1'b0;
        if (wr_en) begin
            unique case (addr)
                ADDR_MASK: begin
                    st_next.mask = wdata[MASKABLE-1:0];
                    st_next.mask_block = 1'b1;
                end
                ADDR_CTRL: st_next.ctrl = wdata[7:0];
                ADDR_IDLE: idle_cmd = 1'b1;
                ADDR_PWR: begin
                    st_next.pwd_force = wdata[PWR_FORCE_BIT];
                    // Entering dormancy only from the power-down handler
                    if (wdata[PWR_WAKE_BIT] && st_reg.pwd_active) begin
                        st_next.ps = PS_DOWN;
                    end
                end
                default: ;
            endcase
        end
        if (rd_en) begin
            unique case (addr)
                ADDR_MASK: st_next.rdata = {21'h0, st_reg.mask};
                ADDR_CTRL: st_next.rdata = {24'h0, st_reg.ctrl};
                ADDR_STAT: st_next.rdata = {17'h0, st_reg.ps, st_reg.active};
                ADDR_PEND: st_next.rdata = {20'h0, raw_req, st_reg.pwd_pend};
                ADDR_IDLE: st_next.rdata = {29'h0, st_reg.div_code};
                ADDR_SP: st_next.rdata = {28'h0, st_reg.sp};
                default: st_next.rdata = 32'h0000_0000;
            endcase
        end
        // Mask-write block and global enable gate everything
        take = win_valid && st_reg.ctrl[CTRL_GEN] && !st_reg.mask_block
            && (st_reg.ps == PS_RUN || st_reg.ps == PS_IDLE);
        if (int_return && st_reg.sp != 4'h0) begin
            st_next.sp = st_reg.sp - 4'h1;
            st_next.status_out = st_reg.stack[st_reg.sp - 4'h1];
            for (int i = 0; i < NUM_SRC; i++) begin
                if (st_reg.active[i]) begin
                    st_next.active = st_reg.active & ~(12'h001 << i);
                    break;
                end
            end
            if (st_reg.active[SRC_PWRDN]) begin
                st_next.pwd_active = 1'b0;
            end
        end else if (take) begin
            st_next.int_take = 1'b1;
            st_next.active = st_reg.active | (12'h001 << win_idx);
            st_next.int_vector = VEC_BASE + 14'(win_idx - 4'h1) * VEC_STEP;
            if (win_idx == 4'(SRC_PWRDN)) begin
                st_next.int_vector = VEC_PWRDN;
                st_next.pwd_pend = 1'b0;
                st_next.pwd_active = 1'b1;
            end else begin
                serviced = 11'(1) << (win_idx - 4'h1);
            end
            if (st_reg.sp == 4'(STACK_DEPTH)) begin
                st_next.ovf = 1'b1;
            end else begin
                st_next.stack[st_reg.sp] = status_in;
                st_next.sp = st_reg.sp + 4'h1;
            end
        end
        // Low-power sequencer; DMA requests keep latching throughout
        unique case (st_reg.ps)
            PS_RUN: begin
                st_next.clk_en = 1'b1;
                if (idle_cmd) begin
                    st_next.ps = PS_IDLE;
                    st_next.core_run = 1'b0;
                    st_next.div_code = (wdata[2:0] > DIV_CODE_128) ? DIV_CODE_NONE : wdata[2:0];
                    st_next.div_cnt = 8'h00;
                end
            end
            PS_IDLE: begin
                // Divided clock enable for core, serial, output and timer
                if (st_reg.div_code == DIV_CODE_NONE) begin
                    st_next.clk_en = 1'b1;
                end else begin
                    st_next.div_cnt = (st_reg.div_cnt + 8'h01 == div_len) ? 8'h00
                        : st_reg.div_cnt + 8'h01;
                    st_next.clk_en = (st_reg.div_cnt == 8'h00);
                end
                if (take) begin
                    if (st_reg.div_code == DIV_CODE_NONE) begin
                        st_next.ps = PS_RUN;
                        st_next.core_run = 1'b1;
                    end else begin
                        st_next.ps = PS_SLOW_EXIT;
                    end
                end
            end
            PS_SLOW_EXIT: begin
                // Resume at next divided tick, within divisor cycles
                st_next.div_cnt = st_reg.div_cnt + 8'h01;
                st_next.clk_en = 1'b0;
                if (st_reg.div_cnt + 8'h01 >= div_len) begin
                    st_next.ps = PS_RUN;
                    st_next.core_run = 1'b1;
                    st_next.clk_en = 1'b1;
                end
            end
            PS_DOWN: begin
                st_next.ack = 1'b1;
                st_next.core_run = 1'b0;
                st_next.clk_en = 1'b0;
                if (!power_down_request_pin_n || (wr_en && addr == ADDR_PWR
                    && !wdata[PWR_WAKE_BIT])) begin
                    st_next.ps = PS_WAKE;
                    st_next.wait_cnt = 14'h0000;
                end
            end
            PS_WAKE: begin
                st_next.ack = 1'b0;
                st_next.wait_cnt = st_reg.wait_cnt + 14'h0001;
                if (st_reg.wait_cnt + 14'h0001 >= wake_len) begin
                    st_next.ps = PS_RUN;
                    st_next.core_run = 1'b1;
                    st_next.clk_en = 1'b1;
                    st_next.ctx_clear = st_reg.ctrl[CTRL_CTX_RESET];
                    if (st_reg.ctrl[CTRL_CTX_RESET]) begin
                        st_next.int_vector = VEC_RESET;
                        st_next.int_take = 1'b1;
                        st_next.sp = 4'h0;
                        st_next.active = 12'h000;
                        st_next.pwd_active = 1'b0;
                    end
                end
            end
        endcase
        st_next.alt_flag_out = sp1_alt ? flag_out_value : 1'b0;
        st_next.alt_flag_in_seen = sp1_alt ? alt_flag_in : 1'b0;
    end

    // Reset ends power-down and restarts at the reset vector
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
            st_reg.ctrl <= CTRL_RESET;
            st_reg.ps <= PS_RUN;
            st_reg.pwd_pin_prev_n <= 1'b1;
            st_reg.core_run <= 1'b1;
            st_reg.clk_en <= 1'b1;
            st_reg.int_vector <= VEC_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata = st_reg.rdata;
    assign status_out = st_reg.status_out;
    assign int_take = st_reg.int_take;
    assign int_vector = st_reg.int_vector;
    assign alt_flag_out = st_reg.alt_flag_out;
    assign alt_flag_in_seen = st_reg.alt_flag_in_seen;
    assign power_down_ack_pin = st_reg.ack;
    assign ctx_clear = st_reg.ctx_clear;
    assign core_run = st_reg.core_run;
    assign clk_en = st_reg.clk_en;
    assign stack_overflow = st_reg.ovf;
endmodule
`default_nettype wire

//--- rtl/dilp_sense.sv
// Edge or level sensing with a latched pending flag for one request input
`timescale 1ns/1ps
`default_nettype none
module dilp_sense
    import dilp_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic req_n,
    input wire logic edge_mode,
    input wire logic force_set,
    input wire logic clear,
    output logic request
);
    typedef struct packed {
        logic prev_n;
        logic pend;
    } dilp_sense_st_t;
    dilp_sense_st_t st_reg;
    dilp_sense_st_t st_next;
    always_comb begin
        st_next = st_reg;
        st_next.prev_n = req_n;
        if (clear) begin
            st_next.pend = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (force_set || (edge_mode && st_reg.prev_n && !req_n)) begin
            st_next.pend = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '{prev_n: 1'b1, pend: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end
    assign request = edge_mode ? st_reg.pend : (!req_n || st_reg.pend);
endmodule
`default_nettype wire

//--- shared/dilp_pkg.sv
// Constants and types for the interrupt and low-power controller
package dilp_pkg;
    localparam int NUM_SRC = 12;
    localparam int STACK_DEPTH = 12;
    localparam logic [13:0] VEC_RESET = 14'h0000;
    localparam logic [13:0] VEC_PWRDN = 14'h002c;
    localparam logic [13:0] VEC_BASE = 14'h0004;
    localparam logic [13:0] VEC_STEP = 14'h0004;
    // Source indices, highest priority first
    localparam int SRC_PWRDN = 0;
    localparam int SRC_PSA = 1;
    localparam int SRC_LVL1 = 2;
    localparam int SRC_LVL0 = 3;
    localparam int SRC_SP0_TX = 4;
    localparam int SRC_SP0_RX = 5;
    localparam int SRC_EDGE = 6;
    localparam int SRC_BYTE_DMA_PORT = 7;
    localparam int SRC_SP1_TX = 8;
    localparam int SRC_SP1_RX = 9;
    localparam int SRC_TIMER = 10;
    localparam int MASKABLE = 11;
    // Register port addresses
    localparam logic [3:0] ADDR_MASK = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h1;
    localparam logic [3:0] ADDR_FC = 4'h2;
    localparam logic [3:0] ADDR_STAT = 4'h3;
    localparam logic [3:0] ADDR_PEND = 4'h4;
    localparam logic [3:0] ADDR_IDLE = 4'h5;
    localparam logic [3:0] ADDR_PWR = 4'h6;
    localparam logic [3:0] ADDR_SP = 4'h7;
    // Control register fields
    localparam int CTRL_SENSE_A = 0;
    localparam int CTRL_SENSE_ALT0 = 1;
    localparam int CTRL_SENSE_ALT1 = 2;
    localparam int CTRL_NEST = 3;
    localparam int CTRL_SP1_ALT = 4;
    localparam int CTRL_GEN = 5;
    localparam int CTRL_OSC_OFF = 6;
    localparam int CTRL_CTX_RESET = 7;
    localparam logic [7:0] CTRL_RESET = 8'h20;
    // Force/clear register: bits 10:0 force, bits 26:16 clear
    localparam int FC_CLR_LSB = 16;
    localparam int PWR_FORCE_BIT = 0;
    localparam int PWR_WAKE_BIT = 1;
    // Times at 200 MHz, input clock period 10 ns (half instruction rate)
    localparam int CLK_MHZ = 200;
    localparam int MASTER_CLOCK_INPUT_PERIOD_NS = 10;
    localparam int RECOVER_MASTER_CLOCK_INPUT = 400;
    localparam int OSC_WAIT_MASTER_CLOCK_INPUT = 4096;
    localparam int RECOVER_CYC = RECOVER_MASTER_CLOCK_INPUT * MASTER_CLOCK_INPUT_PERIOD_NS * CLK_MHZ / 1000;
    localparam int OSC_WAIT_CYC = OSC_WAIT_MASTER_CLOCK_INPUT * MASTER_CLOCK_INPUT_PERIOD_NS * CLK_MHZ / 1000;
    localparam logic [2:0] DIV_CODE_NONE = 3'h0;
    localparam logic [2:0] DIV_CODE_16 = 3'h1;
    localparam logic [2:0] DIV_CODE_128 = 3'h4;
    localparam logic [7:0] DIV_BASE = 8'h08;
    typedef enum logic [2:0] {
        PS_RUN = 3'b000,
        PS_IDLE = 3'b001,
        PS_DOWN = 3'b010,
        PS_WAKE = 3'b011,
        PS_SLOW_EXIT = 3'b100
    } dilp_pstate_t;
endpackage

//--- sim/dilp_ctrl_props.sv
// Property checker for the interrupt and low-power controller
`timescale 1ns/1ps
`default_nettype none
module dilp_ctrl_props
    import dilp_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] addr,
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic [31:0] rdata,
    input wire logic int_take,
    input wire logic [13:0] int_vector,
    input wire logic power_down_ack_pin,
    input wire logic ctx_clear,
    input wire logic core_run,
    input wire logic stack_overflow
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_rd_wo;
        $past(rd_en) && ($past(addr) == ADDR_FC || $past(addr) > 4'h7) |-> rdata == 32'h0;
    endproperty
    property p_vec_form;
        int_take |-> int_vector[1:0] == 2'h0 && int_vector <= VEC_PWRDN
            && (int_vector != VEC_RESET || ctx_clear);
    endproperty
    property p_vec_hold; !int_take |-> $stable(int_vector); endproperty
    // Block applies at the edge after the write, so the pulse is missing one edge later
    property p_mask_block; wr_en && addr == ADDR_MASK |-> ##2 !int_take; endproperty
    property p_ovf_sticky; stack_overflow |=> stack_overflow; endproperty
    property p_ctx_pulse; ctx_clear |=> !ctx_clear; endproperty
    property p_ack_halt; power_down_ack_pin |-> !core_run; endproperty
    property p_wake_wait; $fell(power_down_ack_pin) |-> !core_run [*8]; endproperty
    a_rd_wo: assert property (p_rd_wo) else $error("write-only or unmapped read not zero");
    a_vec_form: assert property (p_vec_form) else $error("vector outside table");
    a_vec_hold: assert property (p_vec_hold) else $error("vector moved without take");
    a_mask_block: assert property (p_mask_block) else $error("take after mask write");
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag dropped");
    a_ctx_pulse: assert property (p_ctx_pulse) else $error("context clear too long");
    a_ack_halt: assert property (p_ack_halt) else $error("core runs while dormant");
    a_wake_wait: assert property (p_wake_wait) else $error("wake without wait");
    c_pwd_take: cover property (int_take && int_vector == VEC_PWRDN);
    c_ack: cover property ($rose(power_down_ack_pin));
    c_wake: cover property ($fell(power_down_ack_pin));
endmodule
bind dilp_ctrl dilp_ctrl_props u_props (.clk, .arst_n, .addr, .rd_en, .wr_en, .rdata, .int_take,
    .int_vector, .power_down_ack_pin, .ctx_clear, .core_run, .stack_overflow);
`default_nettype wire

//--- sim/dilp_src_model.sv
// Model of the external interrupt pins and on-chip request lines
`timescale 1ns/1ps
`default_nettype none
module dilp_src_model (
    input wire logic clk,
    input wire logic [4:0] pin_lo,
    input wire logic [5:0] per_req,
    output logic [4:0] pins_n,
    output logic [5:0] reqs
);
    // Sources are synchronous here; a free-running source would need a synchroniser
    always_ff @(posedge clk) begin
        pins_n <= ~pin_lo;
        reqs <= per_req;
    end
endmodule
`default_nettype wire

//--- sim/dsp_interrupt_and_low_power_control_tb.sv
// Testbench for the interrupt and low-power controller
`timescale 1ns/1ps
`default_nettype none
module dsp_interrupt_and_low_power_control_tb
    import dilp_pkg::*;
;
    logic clk, arst_n, wr_en, rd_en, int_return, int_take, ack, core_run;
    logic [3:0] addr;
    logic [31:0] wdata, rdata;
    logic [13:0] int_vector;
    logic [4:0] pin_lo, pins_n;
    logic [5:0] per_req, reqs;
    int mismatches = 0, n_compared = 0, cyc = 0;
    int n_take = 0, seen = 0;
    logic [13:0] last_vec;
    dilp_src_model src (.clk(clk), .pin_lo(pin_lo), .per_req(per_req), .pins_n(pins_n), .reqs(reqs));
    dilp_ctrl dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .prog_sense_int_pin_a_n(pins_n[2]),
        .level_int_pin_0_n(pins_n[0]), .level_int_pin_1_n(pins_n[1]), .edge_int_pin_n(pins_n[3]),
        .alt_int_pin_0_n(1'b1), .alt_int_pin_1_n(1'b1), .alt_flag_in(1'b0),
        .power_down_request_pin_n(pins_n[4]), .sp0_tx_req(reqs[0]), .sp0_rx_req(reqs[1]),
        .sp1_tx_req(reqs[2]), .sp1_rx_req(reqs[3]), .byte_dma_port_req(reqs[4]), .timer_req(reqs[5]),
        .flag_out_value(1'b0), .int_return(int_return), .status_in(16'h0), .status_out(),
        .int_take(int_take), .int_vector(int_vector), .alt_flag_out(), .alt_flag_in_seen(),
        .power_down_ack_pin(ack), .ctx_clear(), .core_run(core_run), .clk_en(),
        .stack_overflow());
    always #2.5 clk = ~clk;
    // Take pulse stands one cycle; counted here so no task can miss it
    always @(negedge clk) begin
        if (int_take === 1'b1) begin
            n_take <= n_take + 1;
            last_vec <= int_vector;
        end
    end
    task results;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Ceiling covers one wake wait plus short tests with margin
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            mismatches++;
            results;
        end
    end
    task chk32(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %0t data %h expected %h", $time, g, e);
        end
    endtask
    task chk1(input logic g, input logic e);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %0t flag %b expected %b", $time, g, e);
        end
    endtask
    task fin(input string s); $display("%0t test %s done", $time, s); endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk); addr <= a; wdata <= d; wr_en <= 1'b1;
        @(posedge clk); wr_en <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk); addr <= a; rd_en <= 1'b1;
        @(posedge clk); rd_en <= 1'b0;
        #1 chk32(rdata, e);
    endtask
    task ret; @(posedge clk); int_return <= 1'b1; @(posedge clk); int_return <= 1'b0; endtask
    task pins(input logic [4:0] p); @(posedge clk); pin_lo <= p; endtask
    task tick(input logic [5:0] r);
        @(posedge clk); per_req <= r;
        @(posedge clk); per_req <= 6'h0;
    endtask
    task wt(input logic [13:0] e, input int lim);
        for (int i = 0; i < lim && n_take == seen; i++) @(posedge clk);
        chk32({17'h0, n_take != seen, last_vec}, {17'h0, 1'b1, e});
        seen = n_take;
    endtask
    task nt(input int lim);
        repeat (lim) @(posedge clk);
        chk1(n_take != seen, 1'b0);
        seen = n_take;
    endtask
    task t_reset;
        rd(ADDR_CTRL, {24'h0, CTRL_RESET});
        rd(ADDR_FC, 32'h0);
        rd(4'hf, 32'h0);
        fin("reset");
    endtask
    task t_prio;
        wr(ADDR_MASK, 32'h7ff); pins(5'h03); tick(6'h20);
        wt(14'h0008, 10);
        pins(5'h00); ret;
        wt(14'h0028, 10);
        ret; fin("priority");
    endtask
    task t_mask;
        wr(ADDR_MASK, 32'h0); tick(6'h20);
        nt(20);
        wr(ADDR_MASK, 32'h200);
        wt(14'h0028, 10);
        ret; fin("mask");
    endtask
    task t_force;
        wr(ADDR_MASK, 32'h0); wr(ADDR_FC, 32'h20); wr(ADDR_FC, 32'h200000); wr(ADDR_MASK, 32'h20);
        nt(20);
        pins(5'h08); pins(5'h00);
        wt(14'h0018, 10);
        ret; wr(ADDR_FC, 32'h20);
        wt(14'h0018, 10);
        ret; fin("force");
    endtask
    task t_gen;
        wr(ADDR_CTRL, 32'h0); wr(ADDR_MASK, 32'h200); tick(6'h20);
        nt(20);
        wr(ADDR_CTRL, 32'h20);
        wt(14'h0028, 10);
        ret; fin("global");
    endtask
    task t_nest;
        wr(ADDR_CTRL, 32'h28); wr(ADDR_MASK, 32'h202); tick(6'h20);
        wt(14'h0028, 10);
        pins(5'h02);
        wt(14'h0008, 10);
        pins(5'h00);
        nt(4);
        ret; ret; fin("nested");
    endtask
    task t_pwrdn;
        int n;
        wr(ADDR_MASK, 32'h0); pins(5'h10); pins(5'h00);
        wt(VEC_PWRDN, 10);
        wr(ADDR_PWR, 32'h2);
        n = 0;
        while (ack !== 1'b1 && n < 50) begin @(posedge clk); #1; n++; end
        chk1(ack, 1'b1);
        wr(ADDR_PWR, 32'h0);
        n = 0;
        while (core_run !== 1'b1 && n < 2 * RECOVER_CYC) begin @(posedge clk); #1; n++; end
        chk1(n >= RECOVER_CYC - 4 && n <= RECOVER_CYC + 4, 1'b1);
        ret; fin("power-down");
    endtask
    task t_idle;
        int n;
        wr(ADDR_MASK, 32'h200); wr(ADDR_IDLE, 32'h2);
        rd(ADDR_IDLE, 32'h2);
        tick(6'h20);
        wt(14'h0028, 40);
        for (n = 0; n < 40 && core_run !== 1'b1; n++) begin @(posedge clk); #1; end
        chk1(n <= 32, 1'b1);
        ret; fin("idle");
    endtask
    initial begin
        clk = 0; arst_n = 0; addr = 0; wdata = 0; wr_en = 0; rd_en = 0;
        int_return = 0; pin_lo = 0; per_req = 0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        t_reset; t_prio; t_mask; t_force; t_gen; t_nest; t_pwrdn; t_idle;
        results;
    end
endmodule
`default_nettype wire
